// >>> fcrs_cpu_model.sv
`timescale 1ns/1ns
module fcrs_cpu_model (
    // Clock
    input wire logic clk,
    // Write channels
    output logic awvalid,
    input wire logic awready,
    output logic [7:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    // Read channels
    output logic arvalid,
    input wire logic arready,
    output logic [7:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    // Cycles the software dawdles before taking an answer
    int lag = 0;
    // Idle bus at time zero
    initial begin
        {awvalid, wvalid, arvalid, bready, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
    end
    // Released address and data lines show inverted junk, never the old value; wstrb keeps 4'hF
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, output logic ok);
        {ok, r} = 3'h3;
        {awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, 4'hF, 2'h3};
        for (int i = 0; i < 100 && !ok; i++) begin
            bready <= (i >= lag);
            @(posedge clk);
            if (awvalid && awready) {awvalid, awaddr} <= {1'h0, ~a};
            if (wvalid && wready) {wvalid, wdata} <= {1'h0, ~d};
            if (bvalid && bready) begin
                {r, ok} = {bresp, 1'h1};
                bready <= 1'h0;
            end
        end
        // Let an edge pass so the next call never drives bready twice in one step
        if (ok) @(posedge clk);
    endtask
    // One read, answer taken at the edge it is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, output logic ok);
        {ok, r, d} = 35'h0;
        {araddr, arvalid} <= {a, 1'h1};
        for (int i = 0; i < 100 && !ok; i++) begin
            rready <= (i >= lag);
            @(posedge clk);
            if (arvalid && arready) {arvalid, araddr} <= {1'h0, ~a};
            if (rvalid && rready) begin
                {d, r, ok} = {rdata, rresp, 1'h1};
                rready <= 1'h0;
            end
        end
        // Same spacing rule for rready
        if (ok) @(posedge clk);
    endtask
endmodule // fcrs_cpu_model

// >>> fcrs_op_if.sv
`timescale 1ns/1ns
// Start of a timed flash operation and its busy answer
interface fcrs_op_if;
    logic start;
    logic erase;
    logic busy;
    modport ctrl (output start, output erase, input busy);
    modport engine (input start, input erase, output busy);
endinterface

// >>> fcrs_op_timer.sv
`timescale 1ns/1ns
module fcrs_op_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Operation handshake
    fcrs_op_if.engine op
);
    import fcrs_pkg::*;

    typedef struct packed {
        logic busy;
        logic [CNT_W-1:0] cnt;
    } fcrs_timer_t;

    fcrs_timer_t r;
    fcrs_timer_t next_r;

    // Load the duration on start, count down to ready
    always_comb begin
        next_r = r;
        if (r.busy) begin
            if (r.cnt == CNT_W'(1)) begin
                next_r.busy = 1'b0;
            end
            next_r.cnt = r.cnt - CNT_W'(1);
        end else if (op.start) begin
            next_r.busy = 1'b1;
            next_r.cnt = op.erase ? CNT_W'(ERASE_CYCLES) : CNT_W'(PROG_CYCLES);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign op.busy = r.busy;
endmodule // fcrs_op_timer

// >>> fcrs_pkg.sv
package fcrs_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD_ADDR = 8'h04;
    localparam logic [7:0] OFF_CMD_DATA = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_LOCK = 8'h10;
    localparam logic [7:0] OFF_RESULT = 8'h14;
    // Control fields
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_LOCK_INV_BIT = 1;
    // Status byte and status register fields
    localparam int ST_READY_BIT = 7;
    localparam int ST_ERASE_ERR_BIT = 5;
    localparam int ST_PROG_ERR_BIT = 4;
    localparam int ST_RDY_BUSY_BIT = 8;
    localparam int ST_MODE_ON_BIT = 9;
    // Flash address layout
    localparam int ADDR_W = 24;
    localparam int BLOCK_LSB = 16;
    localparam int BLOCK_W = 3;
    localparam int NUM_BLOCKS = 8;
    // Command codes
    localparam logic [7:0] CMD_PROGRAM = 8'h41;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERASE_ALL = 8'hA7;
    localparam logic [7:0] CMD_LOCK_READ = 8'h71;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Operation times
    localparam int CLK_HZ = 20_000_000;
    localparam int PROG_TIME_NS = 10_000;
    localparam int ERASE_TIME_NS = 100_000;
    localparam int PROG_CYCLES = (PROG_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ERASE_CYCLES = (ERASE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CNT_W = 12;
    // Flash operation kinds
    typedef enum logic [1:0] {
        FCRS_OP_PROGRAM = 2'b00,
        FCRS_OP_ERASE_BLOCK = 2'b01,
        FCRS_OP_ERASE_ALL = 2'b10
    } fcrs_op_t;
    // Read mode of the sequencer
    typedef enum logic [1:0] {
        FCRS_RD_ARRAY = 2'b00,
        FCRS_RD_STATUS = 2'b01,
        FCRS_RD_LOCK = 2'b10
    } fcrs_rd_t;
    // Command cycle state
    typedef enum logic {
        FCRS_SEQ_FIRST = 1'b0,
        FCRS_SEQ_SECOND = 1'b1
    } fcrs_seq_t;
endpackage

// >>> fcrs_seq_sva.sv
`timescale 1ns/1ns
module fcrs_seq_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register bus
    input wire logic [7:0] awaddr,
    input wire logic [31:0] wdata,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [7:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [1:0] rresp,
    // Flash operation
    input wire logic op_valid,
    input wire fcrs_pkg::fcrs_op_t op_kind,
    input wire logic [fcrs_pkg::ADDR_W-1:0] op_addr,
    input wire logic [15:0] op_data,
    input wire logic ready_busy_bit
);
    import fcrs_pkg::*;
    // Erase busy is too long for a plain delay, so it is counted
    localparam int MAX_LOW = ERASE_CYCLES + 1;
    int low_cnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Run length of busy
    always_ff @(posedge clk) begin
        low_cnt <= (reset || ready_busy_bit) ? 0 : low_cnt + 1;
    end
    AST_OP_PULSE: assert property (op_valid |=> !op_valid)
        else $error("op start wider than one cycle");
    AST_OP_BUSY: assert property (op_valid |-> !ready_busy_bit && bvalid)
        else $error("op start without busy and response");
    AST_BUSY_CAUSE: assert property ($fell(ready_busy_bit) |-> op_valid)
        else $error("busy without op start");
    AST_PROG_TIME: assert property (op_valid && op_kind == FCRS_OP_PROGRAM
        |-> ##200 !ready_busy_bit ##1 ready_busy_bit) else $error("program busy length wrong");
    AST_ERASE_TIME: assert property (low_cnt <= MAX_LOW)
        else $error("busy longer than an erase");
    // Address and data are released at their taking edge, two edges before the start pulse
    AST_PROG_DATA: assert property (op_valid && op_kind == FCRS_OP_PROGRAM
        |-> op_data == $past(wdata[15:0], 2) && $past(awaddr, 2) == OFF_CMD_DATA)
        else $error("program data not last write");
    AST_CMD_EVEN: assert property (op_valid |-> !op_addr[0])
        else $error("op from odd address");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rresp))
        else $error("read response dropped early");
    AST_UNMAPPED: assert property (arvalid && arready && araddr > OFF_RESULT |=> rvalid && rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
    // Main scenarios
    CV_PROG: cover property (op_valid && op_kind == FCRS_OP_PROGRAM);
    CV_ERASE: cover property (op_valid && op_kind == FCRS_OP_ERASE_BLOCK);
    CV_ALL: cover property (op_valid && op_kind == FCRS_OP_ERASE_ALL);
    CV_SLVERR: cover property (rvalid && rresp == RESP_SLVERR);
endmodule // fcrs_seq_sva
bind fcrs_sequencer fcrs_seq_sva u_sva (.clk, .reset, .awaddr, .wdata, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rresp, .op_valid, .op_kind, .op_addr, .op_data, .ready_busy_bit);

// >>> fcrs_sequencer.sv
`timescale 1ns/1ns
module fcrs_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Flash array operation request
    output logic op_valid,
    output fcrs_pkg::fcrs_op_t op_kind,
    output logic [fcrs_pkg::ADDR_W-1:0] op_addr,
    output logic [15:0] op_data,
    // Ready/busy state
    output logic ready_busy_bit
);
    import fcrs_pkg::*;

    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic w_any;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic mode_sel;
        logic mode_on;
        logic lock_inv;
        logic [NUM_BLOCKS-1:0] lock_bits;
        logic [ADDR_W-1:0] cmd_addr;
        fcrs_rd_t rd_mode;
        fcrs_seq_t seq;
        logic [7:0] first_cmd;
        logic erase_err;
        logic prog_err;
        logic lock_result;
        logic start;
        logic start_erase;
        logic op_valid;
        fcrs_op_t op_kind;
        logic [ADDR_W-1:0] op_addr;
        logic [15:0] op_data;
    } fcrs_state_t;

    fcrs_state_t r;
    fcrs_state_t next_r;
    fcrs_op_if op_bus ();

    // Timed program and erase engine
    fcrs_op_timer u_timer (
        .clk(clk),
        .reset(reset),
        .op(op_bus.engine)
    );

    assign op_bus.start = r.start;
    assign op_bus.erase = r.start_erase;

    logic ready;
    logic [7:0] status_byte;
    logic [7:0] cmd_byte;
    logic target_locked;
    logic do_write;

    // Busy covers the start cycle so no command slips in before the timer
    assign ready = !(op_bus.busy || r.start);

    // Status byte built from the named bit positions
    always_comb begin
        status_byte = 8'h00;
        status_byte[ST_READY_BIT] = ready;
        status_byte[ST_ERASE_ERR_BIT] = r.erase_err;
        status_byte[ST_PROG_ERR_BIT] = r.prog_err;
    end

    assign cmd_byte = r.w_data[7:0];
    assign target_locked = r.lock_bits[r.cmd_addr[BLOCK_LSB +: BLOCK_W]] && !r.lock_inv;
    assign do_write = r.aw_held && r.w_held && !r.bvalid;

    // Bus slave, mode control and command sequencer
    always_comb begin
        next_r = r;
        next_r.start = 1'b0;
        next_r.start_erase = 1'b0;
        next_r.op_valid = 1'b0;
        if (awvalid && !r.aw_held) begin
            next_r.aw_held = 1'b1;
            next_r.aw_addr = awaddr;
        end
        if (wvalid && !r.w_held) begin
            next_r.w_held = 1'b1;
            next_r.w_data = wdata;
            next_r.w_any = |wstrb;
        end
        if (r.bvalid && bready) begin
            next_r.bvalid = 1'b0;
        end
        if (do_write) begin
            next_r.aw_held = 1'b0;
            next_r.w_held = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = RESP_OKAY;
            unique case (r.aw_addr)
                OFF_CTRL: begin
                    if (r.w_any) begin
                        next_r.mode_sel = r.w_data[CTRL_MODE_BIT];
                        // Only a 0 then 1 sequence turns the mode on
                        next_r.mode_on = r.w_data[CTRL_MODE_BIT] && (r.mode_on || !r.mode_sel);
                        next_r.lock_inv = r.w_data[CTRL_LOCK_INV_BIT];
                        if (!r.w_data[CTRL_MODE_BIT]) begin
                            next_r.seq = FCRS_SEQ_FIRST;
                            next_r.rd_mode = FCRS_RD_ARRAY;
                        end
                    end
                end
                OFF_CMD_ADDR: begin
                    if (r.w_any) begin
                        next_r.cmd_addr = r.w_data[ADDR_W-1:0];
                    end
                end
                OFF_LOCK: begin
                    if (r.w_any) begin
                        next_r.lock_bits = r.w_data[NUM_BLOCKS-1:0];
                    end
                end
                OFF_CMD_DATA: begin
                    // Commands while busy are dropped; software must poll ready first
                    if (r.w_any && r.mode_on && ready) begin
                        if (r.seq == FCRS_SEQ_FIRST) begin
                            if (!r.cmd_addr[0]) begin
                                unique case (cmd_byte)
                                    CMD_READ_ARRAY: next_r.rd_mode = FCRS_RD_ARRAY;
                                    CMD_READ_STATUS: next_r.rd_mode = FCRS_RD_STATUS;
                                    CMD_CLEAR_STATUS: begin
                                        next_r.erase_err = 1'b0;
                                        next_r.prog_err = 1'b0;
                                    end
                                    CMD_PROGRAM: begin
                                        // Back-to-back programs allowed in status mode unless a fault is pending
                                        if (!(r.rd_mode == FCRS_RD_STATUS && r.prog_err)) begin
                                            next_r.seq = FCRS_SEQ_SECOND;
                                            next_r.first_cmd = cmd_byte;
                                        end
                                    end
                                    CMD_BLOCK_ERASE, CMD_ERASE_ALL, CMD_LOCK_READ: begin
                                        next_r.seq = FCRS_SEQ_SECOND;
                                        next_r.first_cmd = cmd_byte;
                                    end
                                    default: ;
                                endcase
                            end
                        end else begin
                            next_r.seq = FCRS_SEQ_FIRST;
                            unique case (r.first_cmd)
                                CMD_PROGRAM: begin
                                    next_r.rd_mode = FCRS_RD_STATUS;
                                    if (target_locked) begin
                                        next_r.erase_err = 1'b1;
                                        next_r.prog_err = 1'b1;
                                    end else if (!r.cmd_addr[0]) begin
                                        next_r.start = 1'b1;
                                        next_r.op_valid = 1'b1;
                                        next_r.op_kind = FCRS_OP_PROGRAM;
                                        next_r.op_addr = r.cmd_addr;
                                        next_r.op_data = r.w_data[15:0];
                                    end
                                end
                                CMD_BLOCK_ERASE, CMD_ERASE_ALL: begin
                                    if (cmd_byte == CMD_CONFIRM) begin
                                        next_r.rd_mode = FCRS_RD_STATUS;
                                        if (r.first_cmd == CMD_BLOCK_ERASE && target_locked) begin
                                            next_r.erase_err = 1'b1;
                                            next_r.prog_err = 1'b1;
                                        end else begin
                                            next_r.start = 1'b1;
                                            next_r.start_erase = 1'b1;
                                            next_r.op_valid = 1'b1;
                                            next_r.op_kind = (r.first_cmd == CMD_ERASE_ALL) ?
                                                FCRS_OP_ERASE_ALL : FCRS_OP_ERASE_BLOCK;
                                            next_r.op_addr = r.cmd_addr;
                                            next_r.op_data = 16'h0000;
                                        end
                                    end
                                end
                                default: begin
                                    // Lock bit status read of the addressed block
                                    next_r.rd_mode = FCRS_RD_LOCK;
                                    next_r.lock_result = r.lock_bits[r.cmd_addr[BLOCK_LSB +: BLOCK_W]];
                                end
                            endcase
                        end
                    end
                end
                OFF_STATUS, OFF_RESULT: ;
                default: next_r.bresp = RESP_SLVERR;
            endcase
        end
        if (r.rvalid && rready) begin
            next_r.rvalid = 1'b0;
        end
        if (arvalid && !r.rvalid) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = RESP_OKAY;
            next_r.rdata = 32'h0000_0000;
            unique case (araddr)
                OFF_CTRL: begin
                    next_r.rdata[CTRL_MODE_BIT] = r.mode_sel;
                    next_r.rdata[CTRL_LOCK_INV_BIT] = r.lock_inv;
                end
                OFF_CMD_ADDR: next_r.rdata[ADDR_W-1:0] = r.cmd_addr;
                OFF_CMD_DATA: ;
                OFF_STATUS: begin
                    next_r.rdata[7:0] = status_byte;
                    next_r.rdata[ST_RDY_BUSY_BIT] = ready;
                    next_r.rdata[ST_MODE_ON_BIT] = r.mode_on;
                end
                OFF_LOCK: next_r.rdata[NUM_BLOCKS-1:0] = r.lock_bits;
                OFF_RESULT: begin
                    // Result follows the read mode the last command left behind
                    unique case (r.rd_mode)
                        FCRS_RD_STATUS: next_r.rdata[7:0] = status_byte;
                        FCRS_RD_LOCK: next_r.rdata[0] = r.lock_result;
                        default: ;
                    endcase
                end
                default: next_r.rresp = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Handshake outputs and registered data
    assign awready = !r.aw_held;
    assign wready = !r.w_held;
    assign arready = !r.rvalid;
    assign bvalid = r.bvalid;
    assign bresp = r.bresp;
    assign rvalid = r.rvalid;
    assign rdata = r.rdata;
    assign rresp = r.rresp;
    assign op_valid = r.op_valid;
    assign op_kind = r.op_kind;
    assign op_addr = r.op_addr;
    assign op_data = r.op_data;
    assign ready_busy_bit = ready;
endmodule // fcrs_sequencer

// >>> tb.sv
`timescale 1ns/1ns
module tb;
    import fcrs_pkg::*;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic op_valid, ready_busy_bit;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    fcrs_op_t op_kind;
    logic [ADDR_W-1:0] op_addr, fa;
    logic [15:0] op_data, fd;
    // Model: expected ops, mode and error flags
    logic [41:0] exp_q[$];
    logic m_mode = 1'h0;
    logic [1:0] m_err = 2'h0;
    int err_total = 0;
    int n_checks = 0;
    int low_cnt = 0;
    int last_low = 0;
    // 50 ns clock
    initial begin
        forever #25 clk = ~clk;
    end
    fcrs_sequencer uut (.clk, .reset, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
        .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .op_valid, .op_kind, .op_addr, .op_data,
        .ready_busy_bit);
    fcrs_cpu_model cpu (.clk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic hung(input logic ok);
        if (ok !== 1'h1) begin
            err_total++;
            give_verdict();
        end
    endtask
    function automatic logic [31:0] stat();
        return {22'h0, m_mode, 2'h3, 1'h0, m_err, 4'h0};
    endfunction
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        logic ok;
        cpu.wr(a, d, r, ok);
        hung(ok);
        chk(r, a > OFF_RESULT ? RESP_SLVERR : RESP_OKAY, "bresp");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        logic ok;
        cpu.rd(a, d, r, ok);
        hung(ok);
        chk(r, a > OFF_RESULT ? RESP_SLVERR : RESP_OKAY, "rresp");
        if (a <= OFF_RESULT) chk(d, e, "rdata");
    endtask
    // One command cycle is an address write and a data write
    task automatic cmd(input logic [ADDR_W-1:0] a, input logic [15:0] c);
        w(OFF_CMD_ADDR, {8'h00, a});
        w(OFF_CMD_DATA, {16'h0000, c});
    endtask
    // Busy length comes from the monitor, so no fixed wait here
    task automatic wait_rdy(input int n);
        for (int i = 0; i < 3000 && ready_busy_bit !== 1'h1; i++) @(posedge clk);
        hung(ready_busy_bit);
        @(posedge clk);
        chk(last_low, n + 1, "busy_len");
    endtask
    // Busy run length and every op start against the model
    always @(posedge clk) begin
        if (ready_busy_bit === 1'h0) begin
            low_cnt <= low_cnt + 1;
        end else if (low_cnt != 0) begin
            last_low <= low_cnt;
            low_cnt <= 0;
        end
        if (op_valid === 1'h1) chk({op_kind, op_addr, op_data}, exp_q.size() ? exp_q.pop_front() : 42'h0, "op");
    end
    // Main sequence; command data with low byte 00 is no command
    initial begin
        void'($urandom(25359));
        repeat (10) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        rd(OFF_STATUS, stat());
        cmd(24'h010000, CMD_PROGRAM);
        cmd(24'h010000, 16'hAB00);
        w(OFF_LOCK, 32'h0);
        w(OFF_CTRL, 32'h0);
        w(OFF_CTRL, 32'h1);
        m_mode = 1'h1;
        rd(OFF_STATUS, stat());
        for (int i = 0; i < 2; i++) begin
            fa = {5'h00, 3'h1, 16'($urandom) & 16'hFFFE};
            fd = 16'($urandom);
            exp_q.push_back({FCRS_OP_PROGRAM, fa, fd});
            cmd(fa, {8'($urandom), CMD_PROGRAM});
            cmd(fa, fd);
            wait_rdy(PROG_CYCLES);
        end
        rd(OFF_RESULT, 32'h80);
        cmd(fa | 24'h1, CMD_PROGRAM);
        cmd(fa, 16'hAB00);
        w(OFF_LOCK, 32'h04);
        cmd(24'h020000, CMD_PROGRAM);
        cmd(24'h020000, fd);
        m_err = 2'h3;
        rd(OFF_STATUS, stat());
        cmd(fa, CMD_PROGRAM);
        cmd(fa, 16'hAB00);
        rd(OFF_STATUS, stat());
        cmd(fa, CMD_CLEAR_STATUS);
        m_err = 2'h0;
        rd(OFF_STATUS, stat());
        // Lock bit read of a locked and a free block, then the other read modes
        cmd(24'h020000, CMD_LOCK_READ);
        cmd(24'h020000, 16'h0000);
        rd(OFF_RESULT, 32'h1);
        cmd(24'h010000, CMD_LOCK_READ);
        cmd(24'h010000, 16'h0000);
        rd(OFF_RESULT, 32'h0);
        cmd(fa, CMD_READ_STATUS);
        rd(OFF_RESULT, 32'h80);
        cmd(fa, CMD_READ_ARRAY);
        rd(OFF_RESULT, 32'h0);
        w(OFF_CTRL, 32'h2);
        w(OFF_CTRL, 32'h3);
        cpu.lag = 3;
        exp_q.push_back({FCRS_OP_ERASE_BLOCK, 24'h020000, 16'h0000});
        cmd(24'h020000, CMD_BLOCK_ERASE);
        cmd(24'h020000, CMD_CONFIRM);
        wait_rdy(ERASE_CYCLES);
        exp_q.push_back({FCRS_OP_ERASE_ALL, 24'h000000, 16'h0000});
        cmd(24'h0, CMD_ERASE_ALL);
        cmd(24'h0, CMD_CONFIRM);
        wait_rdy(ERASE_CYCLES);
        cmd(24'h0, CMD_BLOCK_ERASE);
        cmd(24'h0, 16'h0055);
        w(8'h18, 32'h0);
        rd(8'h18, 32'h0);
        repeat (2) @(posedge clk);
        chk(exp_q.size(), 0, "op_missing");
        give_verdict();
    end
endmodule // tb
